// [spxc_pkg.sv]
// spxc_pkg: offsets, field positions and reset values of the port extended config bank
package spxc_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] SPXC_OFS_LATENCY   = 12'h234;
  localparam logic [11:0] SPXC_OFS_L1SS_HDR  = 12'h240;
  localparam logic [11:0] SPXC_OFS_L1SS_CAP  = 12'h244;
  localparam logic [11:0] SPXC_OFS_L1SS_CTL1 = 12'h248;
  localparam logic [11:0] SPXC_OFS_L1SS_CTL2 = 12'h24C;
  localparam logic [11:0] SPXC_OFS_LINK_ST   = 12'h33C;
  localparam logic [11:0] SPXC_OFS_HOT_MAC   = 12'h340;
  localparam logic [11:0] SPXC_OFS_SIDEBAND  = 12'h344;
  localparam logic [11:0] SPXC_OFS_CPL_FLOW  = 12'h350;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int SPXC_SNP_VAL_LSB  = 0;
  localparam int SPXC_SNP_SCL_LSB  = 10;
  localparam int SPXC_NSNP_VAL_LSB = 16;
  localparam int SPXC_NSNP_SCL_LSB = 26;
  localparam int SPXC_VAL_W        = 10;
  localparam int SPXC_SCL_W        = 3;
  localparam int SPXC_CAP_PCIPM    = 1;
  localparam int SPXC_CAP_ASPM     = 3;
  localparam int SPXC_CAP_L1SS     = 4;
  localparam int SPXC_SB_SEL       = 0;
  localparam int SPXC_SB_ADR_LSB   = 1;
  localparam int SPXC_SB_PEC_DIS   = 9;
  localparam int SPXC_SB_PEC_FAIL  = 29;
  localparam int SPXC_SB_BAD_CMD   = 30;
  localparam int SPXC_FLOW_P1      = 1;
  localparam int SPXC_FLOW_P2      = 2;
  localparam int SPXC_HI_LSB       = 16;

  // ------------------------------------------------------------------
  // fixed values and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] SPXC_L1SS_CAP_ID   = 16'h001E;
  localparam logic [3:0]  SPXC_L1SS_VER      = 4'h1;
  localparam logic [11:0] SPXC_L1SS_NEXT     = 12'h000;
  localparam logic [2:0]  SPXC_CAP_RST       = 3'h5;    // {l1ss, aspm, pcipm} = 1,0,1
  localparam logic [7:0]  SPXC_LINK_ST_RST   = 8'h00;
  localparam logic [15:0] SPXC_HOT_RST       = 16'h0000;
  localparam logic [15:0] SPXC_MAC_RST       = 16'h0004;
  localparam logic [3:0]  SPXC_ADR_HI_RST    = 4'hD;
  localparam logic [2:0]  SPXC_SCALE_MAX     = 3'h5;
  localparam logic [31:0] SPXC_ZERO          = 32'h0000_0000;

  // latency unit is 1 ns per code step at scale 0, times 32 per step
  localparam int SPXC_SCALE_SHIFT = 5;

endpackage

// [spxc_preset_if.sv]
// spxc_preset_if: default-override channel from the sideband master or eeprom loader
`timescale 1ns/100ps
`default_nettype none
interface spxc_preset_if;
  logic        wr;      // one-cycle write strobe
  logic [11:0] addr;    // byte offset of target register
  logic [31:0] data;    // new default value
  modport src (output wr, output addr, output data);
  modport dst (input wr, input addr, input data);
endinterface
`default_nettype wire

// [spxc_latency_calc.sv]
// spxc_latency_calc: decodes a latency value and scale into nanoseconds
`timescale 1ns/100ps
`default_nettype none
module spxc_latency_calc
  import spxc_pkg::*;
(
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset_n,
  input  wire logic [SPXC_VAL_W-1:0] i_value,
  input  wire logic [SPXC_SCL_W-1:0] i_scale,
  output logic      [39:0]           o_ns,
  output logic                       o_bad_scale
);
  logic [39:0] next_ns;
  logic        next_bad;
  logic [39:0] ns;
  logic        bad;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  // value << (5*scale); codes above five are flagged and read zero
  always_comb begin
    next_bad = (i_scale > SPXC_SCALE_MAX);
    next_ns  = 40'(i_value) << (SPXC_SCALE_SHIFT * int'(i_scale));
    if (next_bad) begin
      next_ns = 40'h00_0000_0000;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ns  <= 40'h00_0000_0000;
      bad <= 1'b0;
    end else begin
      ns  <= next_ns;
      bad <= next_bad;
    end
  end

  assign o_ns        = ns;
  assign o_bad_scale = bad;
endmodule
`default_nettype wire

// [spxc_regs.sv]
// spxc_regs: extended configuration register bank of one switch port
`timescale 1ns/100ps
`default_nettype none
module spxc_regs
  import spxc_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // configuration access port
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [11:0] i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // default-override writes from sideband master or eeprom autoload
  input  wire logic        i_preset_wr,
  input  wire logic [11:0] i_preset_addr,
  input  wire logic [31:0] i_preset_data,
  // strap pins for the low slave address bits
  input  wire logic [2:0]  i_addr_strap,
  // sideband engine events
  input  wire logic        i_pec_fail_evt,
  input  wire logic        i_bad_cmd_evt,
  // controls steering the rest of the port
  output logic             o_smbus_mode,
  output logic [6:0]       o_slave_addr,
  output logic             o_pec_check_en,
  output logic             o_pcipm_l11_en,
  output logic             o_aspm_l11_en,
  output logic [2:1]       o_cpl_flow_en,
  output logic [39:0]      o_snoop_ns,
  output logic [39:0]      o_nosnoop_ns,
  output logic             o_bad_scale
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [SPXC_VAL_W-1:0] snp_val, next_snp_val, nsnp_val, next_nsnp_val;
  logic [SPXC_SCL_W-1:0] snp_scl, next_snp_scl, nsnp_scl, next_nsnp_scl;
  logic [2:0]            cap, next_cap;          // {l1ss, aspm, pcipm}
  logic                  pcipm_en, next_pcipm_en;
  logic                  aspm_en, next_aspm_en;
  logic [7:0]            link_st, next_link_st;
  logic [15:0]           hot_st, next_hot_st;
  logic [15:0]           mac_st, next_mac_st;
  logic                  sb_sel, next_sb_sel;
  logic [6:0]            sb_adr, next_sb_adr;
  logic                  pec_dis, next_pec_dis;
  logic                  pec_fail, next_pec_fail;
  logic                  bad_cmd, next_bad_cmd;
  logic [2:1]            flow_en, next_flow_en;
  logic                  strap_pend, next_strap_pend;
  logic [31:0]           rdata, next_rdata;
  logic                  rvalid, next_rvalid;
  logic [31:0]           wmask;
  logic [31:0]           wd;
  logic                  bad_snp, bad_nsnp;

  // byte-enable expansion
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_cfg_be[b]}};
    end
    wd = i_cfg_wdata & wmask;
  end

  spxc_preset_if preset ();
  assign preset.wr   = i_preset_wr;
  assign preset.addr = i_preset_addr;
  assign preset.data = i_preset_data;

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  // software writes honour byte enables; a preset write in the same cycle
  // to a read-only word wins since software cannot write those at all
  always_comb begin
    next_snp_val    = snp_val;
    next_snp_scl    = snp_scl;
    next_nsnp_val   = nsnp_val;
    next_nsnp_scl   = nsnp_scl;
    next_cap        = cap;
    next_pcipm_en   = pcipm_en;
    next_aspm_en    = aspm_en;
    next_link_st    = link_st;
    next_hot_st     = hot_st;
    next_mac_st     = mac_st;
    next_sb_sel     = sb_sel;
    next_sb_adr     = sb_adr;
    next_pec_dis    = pec_dis;
    next_pec_fail   = pec_fail;
    next_bad_cmd    = bad_cmd;
    next_flow_en    = flow_en;
    next_strap_pend = 1'b0;

    // straps captured on the first edge after reset release
    if (strap_pend) begin
      next_sb_adr[2:0] = i_addr_strap;
    end

    if (i_cfg_wr) begin
      unique case (i_cfg_addr)
        SPXC_OFS_LATENCY: begin
          if (i_cfg_be[0]) begin
            next_snp_val[7:0] = wd[7:0];
          end
          if (i_cfg_be[1]) begin
            next_snp_val[9:8] = wd[9:8];
            next_snp_scl      = wd[SPXC_SNP_SCL_LSB +: SPXC_SCL_W];
          end
          if (i_cfg_be[2]) begin
            next_nsnp_val[7:0] = wd[23:16];
          end
          if (i_cfg_be[3]) begin
            next_nsnp_val[9:8] = wd[25:24];
            next_nsnp_scl      = wd[SPXC_NSNP_SCL_LSB +: SPXC_SCL_W];
          end
        end
        SPXC_OFS_L1SS_CTL1: begin
          if (i_cfg_be[0]) begin
            next_pcipm_en = wd[SPXC_CAP_PCIPM];
            next_aspm_en  = wd[SPXC_CAP_ASPM];
          end
        end
        SPXC_OFS_SIDEBAND: begin
          if (i_cfg_be[0]) begin
            next_sb_sel = wd[SPXC_SB_SEL];
            next_sb_adr = wd[SPXC_SB_ADR_LSB +: 7];
          end
          if (i_cfg_be[1]) begin
            next_pec_dis = wd[SPXC_SB_PEC_DIS];
          end
          // write one clears; bits 8, 10..28, 31 are dropped
          if (wd[SPXC_SB_PEC_FAIL]) begin
            next_pec_fail = 1'b0;
          end
          if (wd[SPXC_SB_BAD_CMD]) begin
            next_bad_cmd = 1'b0;
          end
        end
        SPXC_OFS_CPL_FLOW: begin
          if (i_cfg_be[0]) begin
            next_flow_en = wd[SPXC_FLOW_P2:SPXC_FLOW_P1];
          end
        end
        default: begin
          // read-only words and unmapped offsets ignore writes
        end
      endcase
    end

    // default overrides from sideband master or eeprom loader
    if (preset.wr) begin
      unique case (preset.addr)
        SPXC_OFS_L1SS_CAP: begin
          next_cap = {preset.data[SPXC_CAP_L1SS], preset.data[SPXC_CAP_ASPM],
                      preset.data[SPXC_CAP_PCIPM]};
        end
        SPXC_OFS_LINK_ST: begin
          next_link_st = preset.data[7:0];
        end
        SPXC_OFS_HOT_MAC: begin
          next_hot_st = preset.data[15:0];
          next_mac_st = preset.data[31:SPXC_HI_LSB];
        end
        default: begin
        end
      endcase
    end

    // events win over a same-cycle software clear
    if (i_pec_fail_evt && !pec_dis) begin
      next_pec_fail = 1'b1;
    end
    if (i_bad_cmd_evt) begin
      next_bad_cmd = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  // reserved positions are built as zero, never stored
  always_comb begin
    next_rvalid = i_cfg_rd;
    next_rdata  = SPXC_ZERO;
    if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        SPXC_OFS_LATENCY: begin
          next_rdata[SPXC_SNP_VAL_LSB +: SPXC_VAL_W]  = snp_val;
          next_rdata[SPXC_SNP_SCL_LSB +: SPXC_SCL_W]  = snp_scl;
          next_rdata[SPXC_NSNP_VAL_LSB +: SPXC_VAL_W] = nsnp_val;
          next_rdata[SPXC_NSNP_SCL_LSB +: SPXC_SCL_W] = nsnp_scl;
        end
        SPXC_OFS_L1SS_HDR: begin
          next_rdata = {SPXC_L1SS_NEXT, SPXC_L1SS_VER, SPXC_L1SS_CAP_ID};
        end
        SPXC_OFS_L1SS_CAP: begin
          next_rdata[SPXC_CAP_PCIPM] = cap[0];
          next_rdata[SPXC_CAP_ASPM]  = cap[1];
          next_rdata[SPXC_CAP_L1SS]  = cap[2];
        end
        SPXC_OFS_L1SS_CTL1: begin
          next_rdata[SPXC_CAP_PCIPM] = pcipm_en;
          next_rdata[SPXC_CAP_ASPM]  = aspm_en;
        end
        SPXC_OFS_LINK_ST: begin
          next_rdata[7:0] = link_st;
        end
        SPXC_OFS_HOT_MAC: begin
          next_rdata = {mac_st, hot_st};
        end
        SPXC_OFS_SIDEBAND: begin
          next_rdata[SPXC_SB_SEL]              = sb_sel;
          next_rdata[SPXC_SB_ADR_LSB +: 7]     = sb_adr;
          next_rdata[SPXC_SB_PEC_DIS]          = pec_dis;
          next_rdata[SPXC_SB_PEC_FAIL]         = pec_fail;
          next_rdata[SPXC_SB_BAD_CMD]          = bad_cmd;
        end
        SPXC_OFS_CPL_FLOW: begin
          next_rdata[SPXC_FLOW_P2:SPXC_FLOW_P1] = flow_en;
        end
        default: begin
          next_rdata = SPXC_ZERO;    // control two and unmapped read zero
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      snp_val    <= '0;
      snp_scl    <= '0;
      nsnp_val   <= '0;
      nsnp_scl   <= '0;
      cap        <= SPXC_CAP_RST;
      pcipm_en   <= 1'b0;
      aspm_en    <= 1'b0;
      link_st    <= SPXC_LINK_ST_RST;
      hot_st     <= SPXC_HOT_RST;
      mac_st     <= SPXC_MAC_RST;
      sb_sel     <= 1'b1;
      sb_adr     <= {SPXC_ADR_HI_RST, 3'h0};
      pec_dis    <= 1'b1;
      pec_fail   <= 1'b0;
      bad_cmd    <= 1'b0;
      flow_en    <= 2'h0;
      strap_pend <= 1'b1;
      rdata      <= SPXC_ZERO;
      rvalid     <= 1'b0;
    end else begin
      snp_val    <= next_snp_val;
      snp_scl    <= next_snp_scl;
      nsnp_val   <= next_nsnp_val;
      nsnp_scl   <= next_nsnp_scl;
      cap        <= next_cap;
      pcipm_en   <= next_pcipm_en;
      aspm_en    <= next_aspm_en;
      link_st    <= next_link_st;
      hot_st     <= next_hot_st;
      mac_st     <= next_mac_st;
      sb_sel     <= next_sb_sel;
      sb_adr     <= next_sb_adr;
      pec_dis    <= next_pec_dis;
      pec_fail   <= next_pec_fail;
      bad_cmd    <= next_bad_cmd;
      flow_en    <= next_flow_en;
      strap_pend <= next_strap_pend;
      rdata      <= next_rdata;
      rvalid     <= next_rvalid;
    end
  end

  // ------------------------------------------------------------------
  // latency decode
  // ------------------------------------------------------------------
  spxc_latency_calc u_snp (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_value     (snp_val),
    .i_scale     (snp_scl),
    .o_ns        (o_snoop_ns),
    .o_bad_scale (bad_snp)
  );

  spxc_latency_calc u_nsnp (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_value     (nsnp_val),
    .i_scale     (nsnp_scl),
    .o_ns        (o_nosnoop_ns),
    .o_bad_scale (bad_nsnp)
  );

  assign o_bad_scale    = bad_snp | bad_nsnp;
  assign o_cfg_rdata    = rdata;
  assign o_cfg_rvalid   = rvalid;
  assign o_smbus_mode   = sb_sel;
  assign o_slave_addr   = sb_adr;
  assign o_pec_check_en = ~pec_dis;
  assign o_pcipm_l11_en = pcipm_en;
  assign o_aspm_l11_en  = aspm_en;
  assign o_cpl_flow_en  = flow_en;
endmodule
`default_nettype wire

// [spxc_regs_checker.sv]
// spxc_regs_checker: port-level assertions for the port extended config bank
`timescale 1ns/100ps
`default_nettype none
module spxc_regs_checker
  import spxc_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  input wire logic        i_cfg_wr,
  input wire logic        i_cfg_rd,
  input wire logic [11:0] i_cfg_addr,
  input wire logic [3:0]  i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_cfg_rvalid,
  input wire logic        i_preset_wr,
  input wire logic [11:0] i_preset_addr,
  input wire logic [31:0] i_preset_data,
  input wire logic [2:0]  i_addr_strap,
  input wire logic        i_pec_fail_evt,
  input wire logic        i_bad_cmd_evt,
  input wire logic        o_smbus_mode,
  input wire logic [6:0]  o_slave_addr,
  input wire logic        o_pec_check_en,
  input wire logic        o_pcipm_l11_en,
  input wire logic        o_aspm_l11_en,
  input wire logic [2:1]  o_cpl_flow_en,
  input wire logic [39:0] o_snoop_ns,
  input wire logic [39:0] o_nosnoop_ns,
  input wire logic        o_bad_scale
);
  // snoop latency fields of the write data, so $past sees a plain signal
  wire logic [9:0] lat_val = i_cfg_wdata[9:0];
  wire logic [2:0] lat_scl = i_cfg_wdata[12:10];
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  // ----------------------------------------
  // read channel
  // ----------------------------------------
  a_read_answer: assert property (i_cfg_rd |=> o_cfg_rvalid)
    else $error("read request got no answer");
  a_rdata_idle_zero: assert property (!o_cfg_rvalid |-> o_cfg_rdata == SPXC_ZERO)
    else $error("read data not zero while idle");
  a_header_fixed: assert property (
    (i_cfg_rd && i_cfg_addr == SPXC_OFS_L1SS_HDR) |=>
    o_cfg_rdata == {SPXC_L1SS_NEXT, SPXC_L1SS_VER, SPXC_L1SS_CAP_ID})
    else $error("capability header wrong");
  a_ctl2_zero: assert property (
    (i_cfg_rd && i_cfg_addr == SPXC_OFS_L1SS_CTL2) |=> o_cfg_rdata == SPXC_ZERO)
    else $error("second control word not zero");
  // strap capture edge is skipped: the read may see the address before it lands
  a_sideband_view: assert property (
    (i_cfg_rd && i_cfg_addr == SPXC_OFS_SIDEBAND && !i_cfg_wr && $past(i_reset_n)) |=>
    (o_cfg_rdata[0] == o_smbus_mode && o_cfg_rdata[7:1] == o_slave_addr &&
     o_cfg_rdata[9] == !o_pec_check_en && o_cfg_rdata[8] == 1'b0 &&
     o_cfg_rdata[28:10] == 19'h0 && o_cfg_rdata[31] == 1'b0))
    else $error("sideband word disagrees with its outputs");
  // a read request lands two edges after the pulse, with no clearing write in between
  a_bad_cmd_sticky: assert property (
    i_bad_cmd_evt ##1 !(i_cfg_wr && i_cfg_addr == SPXC_OFS_SIDEBAND) ##1
    (i_cfg_rd && i_cfg_addr == SPXC_OFS_SIDEBAND && !i_cfg_wr) |=>
    o_cfg_rdata[SPXC_SB_BAD_CMD])
    else $error("bad command flag not set");
  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  a_ctl_enables: assert property (
    (i_cfg_wr && i_cfg_addr == SPXC_OFS_L1SS_CTL1 && i_cfg_be[0]) |=>
    ({28'h0, o_aspm_l11_en, 1'b0, o_pcipm_l11_en, 1'b0} == ($past(i_cfg_wdata) & 32'h0000_000A)))
    else $error("substate enables not taken");
  a_flow_enables: assert property (
    (i_cfg_wr && i_cfg_addr == SPXC_OFS_CPL_FLOW && i_cfg_be[0]) |=>
    ({29'h0, o_cpl_flow_en, 1'b0} == ($past(i_cfg_wdata) & 32'h0000_0006)))
    else $error("flow enables not taken");
  a_snoop_decode: assert property (
    (i_cfg_wr && i_cfg_addr == SPXC_OFS_LATENCY && i_cfg_be == 4'hF && lat_scl <= SPXC_SCALE_MAX)
    |-> ##2 (o_snoop_ns == (40'($past(lat_val, 2)) << (SPXC_SCALE_SHIFT * $past(lat_scl, 2)))))
    else $error("snoop latency decode wrong");
  a_scale_flag: assert property (
    (i_cfg_wr && i_cfg_addr == SPXC_OFS_LATENCY && i_cfg_be[1] && lat_scl > SPXC_SCALE_MAX)
    |-> ##2 o_bad_scale)
    else $error("illegal scale not flagged");
endmodule
`default_nettype wire

// [spxc_sb_model.sv]
// spxc_sb_model: sideband master and eeprom loader presetting defaults and raising events
`timescale 1ns/100ps
`default_nettype none
module spxc_sb_model (
  input  wire logic        i_clk_sys,
  output logic             o_preset_wr,
  output logic [11:0]      o_preset_addr,
  output logic [31:0]      o_preset_data,
  output logic             o_pec_fail_evt,
  output logic             o_bad_cmd_evt
);
  // idle at time zero
  initial begin
    o_preset_wr = 1'b0;
    o_preset_addr = 12'h000;
    o_preset_data = 32'h0000_0000;
    o_pec_fail_evt = 1'b0;
    o_bad_cmd_evt = 1'b0;
  end
  // one-strobe override; released lines show the inverse so stale data never looks valid
  task automatic preset(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    #1;
    o_preset_wr = 1'b1;
    o_preset_addr = a;
    o_preset_data = d;
    @(posedge i_clk_sys);
    #1;
    o_preset_wr = 1'b0;
    o_preset_addr = ~a;
    o_preset_data = ~d;
  endtask
  // one-cycle event pulse: pec failure when pec is set, else unsupported command
  task automatic pulse(input logic pec);
    @(posedge i_clk_sys);
    #1;
    o_pec_fail_evt = pec;
    o_bad_cmd_evt = !pec;
    @(posedge i_clk_sys);
    #1;
    o_pec_fail_evt = 1'b0;
    o_bad_cmd_evt = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// tb_top: self-checking bench for the port extended config register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import spxc_pkg::*;
;
  logic        i_clk_sys, i_reset_n, i_cfg_wr, i_cfg_rd, o_cfg_rvalid, i_preset_wr;
  logic        i_pec_fail_evt, i_bad_cmd_evt, o_smbus_mode, o_pec_check_en, o_bad_scale;
  logic        o_pcipm_l11_en, o_aspm_l11_en;
  logic [11:0] i_cfg_addr, i_preset_addr;
  logic [3:0]  i_cfg_be;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, i_preset_data;
  logic [2:0]  i_addr_strap;
  logic [6:0]  o_slave_addr;
  logic [2:1]  o_cpl_flow_en;
  logic [39:0] o_snoop_ns, o_nosnoop_ns;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  spxc_regs i_dut (.*);
  spxc_sb_model i_sb (.i_clk_sys(i_clk_sys), .o_preset_wr(i_preset_wr),
    .o_preset_addr(i_preset_addr), .o_preset_data(i_preset_data),
    .o_pec_fail_evt(i_pec_fail_evt), .o_bad_cmd_evt(i_bad_cmd_evt));
  // 100 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cfg_write(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge i_clk_sys);
    #1;
    i_cfg_wr = 1'b1;
    i_cfg_addr = a;
    i_cfg_be = be;
    i_cfg_wdata = d;
    @(posedge i_clk_sys);
    #1;
    i_cfg_wr = 1'b0;
  endtask
  // answer stands one cycle, so it is looked at just after the edge that follows the request
  task automatic check_reg(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_clk_sys);
    #1;
    i_cfg_rd = 1'b1;
    i_cfg_addr = a;
    @(posedge i_clk_sys);
    #1;
    i_cfg_rd = 1'b0;
    chk("rvalid", 40'h1, {39'h0, o_cfg_rvalid});
    chk($sformatf("reg_%h", a), {8'h00, exp}, {8'h00, o_cfg_rdata});
  endtask
  task automatic do_reset(input logic [2:0] strap);
    i_addr_strap = strap;
    i_reset_n = 1'b0;
    repeat (16) @(posedge i_clk_sys);
    #1;
    i_reset_n = 1'b1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values(input logic [6:0] adr);
    check_reg(SPXC_OFS_LATENCY, 32'h0000_0000);
    check_reg(SPXC_OFS_L1SS_HDR, 32'h0001_001E);
    check_reg(SPXC_OFS_L1SS_CAP, 32'h0000_0012);
    check_reg(SPXC_OFS_L1SS_CTL1, 32'h0000_0000);
    check_reg(SPXC_OFS_L1SS_CTL2, 32'h0000_0000);
    check_reg(SPXC_OFS_LINK_ST, 32'h0000_0000);
    check_reg(SPXC_OFS_HOT_MAC, 32'h0004_0000);
    check_reg(SPXC_OFS_SIDEBAND, {22'h0, 1'b1, 1'b0, adr, 1'b1});
    check_reg(SPXC_OFS_CPL_FLOW, 32'h0000_0000);
    check_reg(12'h300, 32'h0000_0000);
    chk("slave_addr", {33'h0, adr}, {33'h0, o_slave_addr});
    chk("smbus_mode", 40'h1, {39'h0, o_smbus_mode});
    chk("pec_check_en", 40'h0, {39'h0, o_pec_check_en});
    $display("test reset_values done");
  endtask
  task automatic t_write_masks();
    logic [11:0] ro[5] = '{SPXC_OFS_L1SS_HDR, SPXC_OFS_L1SS_CAP, SPXC_OFS_L1SS_CTL2,
                           SPXC_OFS_LINK_ST, SPXC_OFS_HOT_MAC};
    foreach (ro[k]) cfg_write(ro[k], 4'hF, 32'hFFFF_FFFF);
    check_reg(SPXC_OFS_L1SS_CAP, 32'h0000_0012);
    check_reg(SPXC_OFS_HOT_MAC, 32'h0004_0000);
    cfg_write(SPXC_OFS_LATENCY, 4'hF, 32'hFFFF_FFFF);
    check_reg(SPXC_OFS_LATENCY, 32'h1FFF_1FFF);
    chk("bad_scale", 40'h1, {39'h0, o_bad_scale});
    cfg_write(SPXC_OFS_LATENCY, 4'h3, 32'h0000_0000);
    check_reg(SPXC_OFS_LATENCY, 32'h1FFF_0000);
    cfg_write(SPXC_OFS_L1SS_CTL1, 4'hF, 32'hFFFF_FFFF);
    check_reg(SPXC_OFS_L1SS_CTL1, 32'h0000_000A);
    cfg_write(SPXC_OFS_CPL_FLOW, 4'hF, 32'hFFFF_FFFF);
    check_reg(SPXC_OFS_CPL_FLOW, 32'h0000_0006);
    cfg_write(SPXC_OFS_SIDEBAND, 4'hF, 32'h0000_0000);
    check_reg(SPXC_OFS_SIDEBAND, 32'h0000_0000);
    chk("pec_check_en", 40'h1, {39'h0, o_pec_check_en});
    $display("test write_masks done");
  endtask
  task automatic t_latency();
    for (int s = 0; s <= 5; s++) begin
      cfg_write(SPXC_OFS_LATENCY, 4'hF, {6'(5 - s), 10'h001, 3'b000, 3'(s), 10'h3FF});
      @(posedge i_clk_sys);
      #1;
      chk("snoop_ns", 40'h3FF << (5 * s), o_snoop_ns);
      chk("nosnoop_ns", 40'h1 << (5 * (5 - s)), o_nosnoop_ns);
      chk("bad_scale", 40'h0, {39'h0, o_bad_scale});
    end
    cfg_write(SPXC_OFS_LATENCY, 4'hF, 32'h1801_0000);
    @(posedge i_clk_sys);
    #1;
    chk("bad_scale", 40'h1, {39'h0, o_bad_scale});
    $display("test latency done");
  endtask
  task automatic t_events();
    i_sb.pulse(1'b0);
    check_reg(SPXC_OFS_SIDEBAND, 32'h4000_0000);
    i_sb.pulse(1'b1);
    check_reg(SPXC_OFS_SIDEBAND, 32'h6000_0000);
    fork
      i_sb.pulse(1'b0);
      cfg_write(SPXC_OFS_SIDEBAND, 4'h8, 32'h4000_0000);
    join
    check_reg(SPXC_OFS_SIDEBAND, 32'h6000_0000);
    cfg_write(SPXC_OFS_SIDEBAND, 4'h8, 32'h6000_0000);
    check_reg(SPXC_OFS_SIDEBAND, 32'h0000_0000);
    cfg_write(SPXC_OFS_SIDEBAND, 4'hF, 32'h0000_0200);
    i_sb.pulse(1'b1);
    check_reg(SPXC_OFS_SIDEBAND, 32'h0000_0200);
    $display("test events done");
  endtask
  task automatic t_presets();
    i_sb.preset(SPXC_OFS_L1SS_CAP, 32'h0000_0008);
    check_reg(SPXC_OFS_L1SS_CAP, 32'h0000_0008);
    i_sb.preset(SPXC_OFS_LINK_ST, 32'hFFFF_FFFF);
    check_reg(SPXC_OFS_LINK_ST, 32'h0000_00FF);
    i_sb.preset(SPXC_OFS_HOT_MAC, 32'h1234_5678);
    check_reg(SPXC_OFS_HOT_MAC, 32'h1234_5678);
    i_sb.preset(SPXC_OFS_L1SS_HDR, 32'h0000_0000);
    check_reg(SPXC_OFS_L1SS_HDR, 32'h0001_001E);
    $display("test presets done");
  endtask
  // main sequence, ending with a second reset in mid-run
  initial begin
    i_cfg_wr = 1'b0;
    i_cfg_rd = 1'b0;
    i_cfg_addr = 12'h000;
    i_cfg_be = 4'h0;
    i_cfg_wdata = 32'h0000_0000;
    do_reset(3'h5);
    t_reset_values(7'h6D);
    t_write_masks();
    t_latency();
    t_events();
    t_presets();
    do_reset(3'h2);
    t_reset_values(7'h6A);
    report_and_stop();
  end
endmodule
bind spxc_regs spxc_regs_checker i_chk (.*);
`default_nettype wire
